// [verilog/bcr_map.svh]
// Register offsets, field positions, reset values and timing counts for the calendar clock
`ifndef BCR_MAP_SVH
`define BCR_MAP_SVH
`define BCR_SEC_OFF 8'h00
`define BCR_MIN_OFF 8'h01
`define BCR_HOUR_OFF 8'h02
`define BCR_DAY_OFF 8'h03
`define BCR_MON_OFF 8'h04
`define BCR_YEAR_OFF 8'h05
`define BCR_WEEK_OFF 8'h06
`define BCR_ASEC_OFF 8'h08
`define BCR_AMIN_OFF 8'h09
`define BCR_AHOUR_OFF 8'h0a
`define BCR_ADAY_OFF 8'h0b
`define BCR_AMON_OFF 8'h0c
`define BCR_AYEAR_OFF 8'h0d
`define BCR_CTRL_OFF 8'h10
`define BCR_STAT_OFF 8'h11
`define BCR_IRQ_OFF 8'h12
`define BCR_COMPL_OFF 8'h13
`define BCR_COMPM_OFF 8'h14
`define BCR_BCK_FIRST_OFF 8'h17
`define BCR_BCK_LAST_OFF 8'h1b
`define BCR_SRC_OFF 8'h1f
// Control register fields
`define BCR_CTRL_RUN_BIT 0
`define BCR_CTRL_ROUND_BIT 1
`define BCR_CTRL_AUTOCOMP_BIT 2
`define BCR_CTRL_MODE12_BIT 3
// Status register fields
`define BCR_STAT_RUN_BIT 1
`define BCR_STAT_TICK_BIT 5
`define BCR_STAT_ALARM_BIT 6
// Interrupt register fields
`define BCR_IRQ_PER_LSB 0
`define BCR_IRQ_TIMER_BIT 2
`define BCR_IRQ_ALARM_BIT 3
`define BCR_IRQ_SLEEPMASK_BIT 4
// Reset values
`define BCR_DAY_RST 8'h01
`define BCR_MON_RST 8'h01
// Timing: prescaler modulus for one second of the 32 kHz source
`define BCR_PRESCALE_COUNT 32768
`endif

// [verilog/bcr_pkg.sv]
// Types shared by the calendar clock files
package bcr_pkg;
  typedef enum logic [1:0] {
    BCR_PER_SEC = 2'b00,
    BCR_PER_MIN = 2'b01,
    BCR_PER_HOUR = 2'b10,
    BCR_PER_DAY = 2'b11
  } bcr_period_t;
  typedef logic [7:0] bcr_byte_t;
endpackage

// [verilog/bcr_prescaler.sv]
// Second-tick prescaler on the 32 kHz enable, with hourly signed drift correction
`timescale 1ns/1ps
`include "bcr_map.svh"
module bcr_prescaler #(
  parameter int CNT_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic tick32_in,
  input wire logic comp_apply_in,
  input wire logic [15:0] comp_in,
  output logic sec_tick_out
);
  localparam logic [CNT_W:0] MODULUS = (CNT_W+1)'(`BCR_PRESCALE_COUNT);
  logic [CNT_W:0] cnt_ff;
  logic [CNT_W:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  // Count 32 kHz edges; a positive correction pre-advances the count so the second shortens
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (run_in && tick32_in) begin
      // Signed compare, so a negative drift start lengthens the second
      if ($signed(cnt_ff) >= $signed(MODULUS - (CNT_W+1)'(1))) begin
        nxt_tick = 1'b1;
        // Signed drift added at the one-second point [R15]
        nxt_cnt = comp_apply_in ? (CNT_W+1)'({{(CNT_W-15){comp_in[15]}}, comp_in}) : '0;
      end else begin
        nxt_cnt = cnt_ff + (CNT_W+1)'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign sec_tick_out = tick_ff;
endmodule

// [verilog/bcr_rtc.sv]
// BCD time and calendar clock core with alarm, periodic event, drift correction and backup bytes
// What this block does
// (R1) Keep seconds to weekday in BCD, calendar valid through year 2099.
// (R2) Year runs 00 to 99; years divisible by four are leap years.
// (R3) Month 01-12; day limit 31, 30, or February 29/28 by leap year.
// (R4) Weekday counter holds 0 through 6 only; a host write of the weekday still stores 7.
// (R5) Hours 00-23 in 24-hour mode; 1-12 plus afternoon flag otherwise.
// (R6) Minutes and seconds count 0-59, wrap, and carry upward.
// (R7) Host may write time registers while the clock runs.
// (R8) Clearing run-enable freezes counting; a status flag shows running.
// (R9) Round-to-minute snaps to nearest minute at next second, then self-clears.
// (R10) Periodic event each second, minute, hour or day as selected.
// (R11) Alarm event on time match; each event has its own enable.
// (R12) Sleep masking suppresses periodic events while asleep, unmasks on wake.
// (R13) Alarm may wake the platform; periodic event never does.
// (R14) Host changes control bit 5 only while the clock is stopped.
// (R15) Hourly, signed drift added to the 32 kHz prescaler at one second.
// (R16) Host reloads drift value before each hourly correction.
// (R17) Drift value acts as soon as written.
// (R18) Five byte-wide backup registers kept while backup supply stays.
// (R19) Boot selects pick default 32 kHz source; a control bit may switch.
// (R20) Afternoon flag in hour bit 7; zero in 24-hour mode.
// (R21) Seconds and minutes: tens in 6:4, units in 3:0, bit 7 zero.
// (R22) Weekday advances at midnight day rollover, wrapping 6 to 0.
`timescale 1ns/1ps
`include "bcr_map.svh"
module bcr_rtc (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick32_in,
  input wire logic sleep_in,
  input wire logic boot_select_0_in,
  input wire logic boot_select_1_in,
  input wire logic [7:0] addr_in,
  input wire bcr_pkg::bcr_byte_t wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output bcr_pkg::bcr_byte_t rdata_out,
  output logic periodic_event_irq_out,
  output logic alarm_event_irq_out,
  output logic wakeup_out,
  output logic crystal_select_out
);
  import bcr_pkg::*;

  // Time and calendar registers
  bcr_byte_t sec_ff, min_ff, hour_ff, day_ff, mon_ff, year_ff, week_ff;
  bcr_byte_t nxt_sec, nxt_min, nxt_hour, nxt_day, nxt_mon, nxt_year, nxt_week;
  bcr_byte_t asec_ff, amin_ff, ahour_ff, aday_ff, amon_ff, ayear_ff;
  bcr_byte_t nxt_asec, nxt_amin, nxt_ahour, nxt_aday, nxt_amon, nxt_ayear;
  bcr_byte_t ctrl_ff, nxt_ctrl, irqc_ff, nxt_irqc, compl_ff, nxt_compl, compm_ff, nxt_compm;
  bcr_byte_t bck_ff [5];
  bcr_byte_t nxt_bck [5];
  logic tick_st_ff, nxt_tick_st, alarm_st_ff, nxt_alarm_st;
  logic xtal_ff, nxt_xtal, strap_done_ff, nxt_strap_done;
  bcr_byte_t rdata_ff, nxt_rdata;
  logic [1:0] t32_sync_ff, boot_select_0_sync_ff, boot_select_1_sync_ff, sleep_sync_ff;
  logic t32_prev_ff;
  logic [1:0] strap_wait_ff;
  logic sec_tick, per_hit, alarm_hit, hour_roll, comp_apply;
  logic mode12;

  // BCD increment with wrap; digit arithmetic shared by every counter except the weekday
  function automatic bcr_byte_t bcd_inc(input bcr_byte_t v, input bcr_byte_t top,
                                         input bcr_byte_t low);
    bcr_byte_t r;
    r = v;
    if (v >= top) begin
      r = low;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = v + 8'h01;
    end
    return r;
  endfunction

  // Last day of the month, leap when the year is divisible by four [R2] [R3]
  function automatic bcr_byte_t month_last(input bcr_byte_t m, input bcr_byte_t y);
    bcr_byte_t r;
    logic leap;
    leap = ((y[4] == 1'b0) && (y[1:0] == 2'b00)) || ((y[4] == 1'b1) && (y[1:0] == 2'b10));
    if (m == 8'h02) begin
      r = leap ? 8'h29 : 8'h28;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      r = 8'h30;
    end else begin
      r = 8'h31;
    end
    return r;
  endfunction

  // Pins and the 32 kHz source cross in through two flops each
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      t32_sync_ff <= 2'h0;
      boot_select_0_sync_ff <= 2'h0;
      boot_select_1_sync_ff <= 2'h0;
      sleep_sync_ff <= 2'h0;
      t32_prev_ff <= 1'b0;
      strap_wait_ff <= 2'h0;
    end else begin
      strap_wait_ff <= {strap_wait_ff[0], 1'b1};
      t32_sync_ff <= {t32_sync_ff[0], tick32_in};
      boot_select_0_sync_ff <= {boot_select_0_sync_ff[0], boot_select_0_in};
      boot_select_1_sync_ff <= {boot_select_1_sync_ff[0], boot_select_1_in};
      sleep_sync_ff <= {sleep_sync_ff[0], sleep_in};
      t32_prev_ff <= t32_sync_ff[1];
    end
  end

  assign mode12 = ctrl_ff[`BCR_CTRL_MODE12_BIT];
  // Correction applies once per hour: the tick that opens the hour sets the length of the next second
  assign comp_apply = ctrl_ff[`BCR_CTRL_AUTOCOMP_BIT] && min_ff == 8'h59 && sec_ff == 8'h59; // [R15]

  bcr_prescaler #(
    .CNT_W(16)
  ) u_prescaler (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .run_in(ctrl_ff[`BCR_CTRL_RUN_BIT]), // [R8]
    .tick32_in(t32_sync_ff[1] && !t32_prev_ff),
    .comp_apply_in(comp_apply),
    .comp_in({compm_ff, compl_ff}), // [R17]
    .sec_tick_out(sec_tick)
  );

  // Counting, rounding and host writes; a host write of a field wins over the tick
  always_comb begin
    bcr_byte_t h;
    logic c_min, c_hour, c_day, c_mon;
    h = 8'h00;
    c_min = 1'b0;
    c_hour = 1'b0;
    c_day = 1'b0;
    c_mon = 1'b0;
    nxt_sec = sec_ff;
    nxt_min = min_ff;
    nxt_hour = hour_ff;
    nxt_day = day_ff;
    nxt_mon = mon_ff;
    nxt_year = year_ff;
    nxt_week = week_ff;
    nxt_ctrl = ctrl_ff;
    hour_roll = 1'b0;
    if (sec_tick) begin
      if (ctrl_ff[`BCR_CTRL_ROUND_BIT]) begin
        nxt_sec = 8'h00; // [R9]
        c_min = (sec_ff >= 8'h30);
        nxt_ctrl[`BCR_CTRL_ROUND_BIT] = 1'b0; // [R9]
      end else begin
        nxt_sec = bcd_inc(sec_ff, 8'h59, 8'h00); // [R6]
        c_min = (sec_ff == 8'h59);
      end
      if (c_min) begin
        nxt_min = bcd_inc(min_ff, 8'h59, 8'h00); // [R6]
        c_hour = (min_ff == 8'h59);
      end
      if (c_hour) begin
        hour_roll = 1'b1;
        h = {2'b00, hour_ff[5:0]};
        if (mode12) begin
          // 11 -> 12 flips the afternoon flag and closes the day at 11 PM -> 12 AM; 12 -> 1 keeps the flag [R5]
          nxt_hour = {hour_ff[7], 1'b0, 6'(bcd_inc(h, 8'h12, 8'h01))};
          if (h == 8'h11) begin
            nxt_hour[7] = ~hour_ff[7]; // [R20]
            c_day = hour_ff[7];
          end
        end else begin
          nxt_hour = bcd_inc(h, 8'h23, 8'h00); // [R5]
          c_day = (h == 8'h23);
        end
      end
      if (c_day) begin
        nxt_week = (week_ff >= 8'h06) ? 8'h00 : week_ff + 8'h01; // [R4] [R22]
        nxt_day = bcd_inc(day_ff, month_last(mon_ff, year_ff), 8'h01); // [R3]
        c_mon = (day_ff >= month_last(mon_ff, year_ff));
      end
      if (c_mon) begin
        nxt_mon = bcd_inc(mon_ff, 8'h12, 8'h01); // [R3]
        if (mon_ff == 8'h12) begin
          nxt_year = bcd_inc(year_ff, 8'h99, 8'h00); // [R1] [R2]
        end
      end
    end
    // Writes land while running; no stop needed [R7]
    if (wr_in) begin
      if (addr_in == `BCR_SEC_OFF) begin
        nxt_sec = {1'b0, wdata_in[6:0]}; // [R21]
      end else if (addr_in == `BCR_MIN_OFF) begin
        nxt_min = {1'b0, wdata_in[6:0]}; // [R21]
      end else if (addr_in == `BCR_HOUR_OFF) begin
        nxt_hour = {wdata_in[7] & mode12, 1'b0, wdata_in[5:0]}; // [R20]
      end else if (addr_in == `BCR_DAY_OFF) begin
        nxt_day = {2'b00, wdata_in[5:0]};
      end else if (addr_in == `BCR_MON_OFF) begin
        nxt_mon = {3'b000, wdata_in[4:0]};
      end else if (addr_in == `BCR_YEAR_OFF) begin
        nxt_year = wdata_in;
      end else if (addr_in == `BCR_WEEK_OFF) begin
        nxt_week = {5'b00000, wdata_in[2:0]};
      end else if (addr_in == `BCR_CTRL_OFF) begin
        nxt_ctrl = wdata_in; // Bit 5 changed only while stopped, by host discipline [R14]
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sec_ff <= 8'h00;
      min_ff <= 8'h00;
      hour_ff <= 8'h00;
      day_ff <= `BCR_DAY_RST;
      mon_ff <= `BCR_MON_RST;
      year_ff <= 8'h00;
      week_ff <= 8'h00;
      ctrl_ff <= 8'h00;
    end else begin
      sec_ff <= nxt_sec;
      min_ff <= nxt_min;
      hour_ff <= nxt_hour;
      day_ff <= nxt_day;
      mon_ff <= nxt_mon;
      year_ff <= nxt_year;
      week_ff <= nxt_week;
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Periodic and alarm detection, evaluated on the freshly updated time
  always_comb begin
    case (bcr_period_t'(irqc_ff[`BCR_IRQ_PER_LSB +: 2]))
      BCR_PER_SEC: per_hit = 1'b1;
      BCR_PER_MIN: per_hit = (nxt_sec == 8'h00);
      BCR_PER_HOUR: per_hit = (nxt_sec == 8'h00) && (nxt_min == 8'h00);
      default: per_hit = (nxt_sec == 8'h00) && (nxt_min == 8'h00) && (nxt_day != day_ff);
    endcase
    alarm_hit = nxt_sec == asec_ff && nxt_min == amin_ff && nxt_hour == ahour_ff &&
                nxt_day == aday_ff && nxt_mon == amon_ff && nxt_year == ayear_ff; // [R11]
  end

  // Alarm, event config, drift value, backup bytes, status and source select
  always_comb begin
    logic st_wr;
    st_wr = wr_in && addr_in == `BCR_STAT_OFF;
    nxt_asec = asec_ff;
    nxt_amin = amin_ff;
    nxt_ahour = ahour_ff;
    nxt_aday = aday_ff;
    nxt_amon = amon_ff;
    nxt_ayear = ayear_ff;
    nxt_irqc = irqc_ff;
    nxt_compl = compl_ff;
    nxt_compm = compm_ff;
    nxt_bck = bck_ff;
    nxt_xtal = xtal_ff;
    nxt_strap_done = strap_wait_ff[1]; // Wait until the strap syncs hold real pin levels
    // Boot straps pick the default source once after reset [R19]
    if (!strap_done_ff) begin
      nxt_xtal = boot_select_0_sync_ff[1] && !boot_select_1_sync_ff[1];
    end
    // Write-one-to-clear; a same-cycle event keeps the flag set
    nxt_tick_st = tick_st_ff & ~(st_wr & wdata_in[`BCR_STAT_TICK_BIT]);
    nxt_alarm_st = alarm_st_ff & ~(st_wr & wdata_in[`BCR_STAT_ALARM_BIT]);
    if (sec_tick && per_hit) begin
      nxt_tick_st = 1'b1; // [R10]
    end
    if (sec_tick && alarm_hit) begin
      nxt_alarm_st = 1'b1; // [R11]
    end
    if (wr_in) begin
      if (addr_in == `BCR_ASEC_OFF) begin
        nxt_asec = {1'b0, wdata_in[6:0]};
      end else if (addr_in == `BCR_AMIN_OFF) begin
        nxt_amin = {1'b0, wdata_in[6:0]};
      end else if (addr_in == `BCR_AHOUR_OFF) begin
        nxt_ahour = {wdata_in[7], 1'b0, wdata_in[5:0]};
      end else if (addr_in == `BCR_ADAY_OFF) begin
        nxt_aday = {2'b00, wdata_in[5:0]};
      end else if (addr_in == `BCR_AMON_OFF) begin
        nxt_amon = {3'b000, wdata_in[4:0]};
      end else if (addr_in == `BCR_AYEAR_OFF) begin
        nxt_ayear = wdata_in;
      end else if (addr_in == `BCR_IRQ_OFF) begin
        nxt_irqc = {3'b000, wdata_in[4:0]};
      end else if (addr_in == `BCR_COMPL_OFF) begin
        nxt_compl = wdata_in; // [R16] [R17]
      end else if (addr_in == `BCR_COMPM_OFF) begin
        nxt_compm = wdata_in; // [R17]
      end else if (addr_in >= `BCR_BCK_FIRST_OFF && addr_in <= `BCR_BCK_LAST_OFF) begin
        nxt_bck[3'(addr_in - `BCR_BCK_FIRST_OFF)] = wdata_in; // [R18]
      end else if (addr_in == `BCR_SRC_OFF) begin
        nxt_xtal = wdata_in[0]; // [R19]
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      asec_ff <= 8'h00;
      amin_ff <= 8'h00;
      ahour_ff <= 8'h00;
      aday_ff <= `BCR_DAY_RST;
      amon_ff <= `BCR_MON_RST;
      ayear_ff <= 8'h00;
      irqc_ff <= 8'h00;
      compl_ff <= 8'h00;
      compm_ff <= 8'h00;
      for (int i = 0; i < 5; i++) begin
        bck_ff[i] <= 8'h00;
      end
      tick_st_ff <= 1'b0;
      alarm_st_ff <= 1'b0;
      xtal_ff <= 1'b0;
      strap_done_ff <= 1'b0;
    end else begin
      asec_ff <= nxt_asec;
      amin_ff <= nxt_amin;
      ahour_ff <= nxt_ahour;
      aday_ff <= nxt_aday;
      amon_ff <= nxt_amon;
      ayear_ff <= nxt_ayear;
      irqc_ff <= nxt_irqc;
      compl_ff <= nxt_compl;
      compm_ff <= nxt_compm;
      bck_ff <= nxt_bck;
      tick_st_ff <= nxt_tick_st;
      alarm_st_ff <= nxt_alarm_st;
      xtal_ff <= nxt_xtal;
      strap_done_ff <= nxt_strap_done;
    end
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_in) begin
      if (addr_in == `BCR_SEC_OFF) begin
        nxt_rdata = sec_ff;
      end else if (addr_in == `BCR_MIN_OFF) begin
        nxt_rdata = min_ff;
      end else if (addr_in == `BCR_HOUR_OFF) begin
        nxt_rdata = hour_ff;
      end else if (addr_in == `BCR_DAY_OFF) begin
        nxt_rdata = day_ff;
      end else if (addr_in == `BCR_MON_OFF) begin
        nxt_rdata = mon_ff;
      end else if (addr_in == `BCR_YEAR_OFF) begin
        nxt_rdata = year_ff;
      end else if (addr_in == `BCR_WEEK_OFF) begin
        nxt_rdata = week_ff;
      end else if (addr_in == `BCR_ASEC_OFF) begin
        nxt_rdata = asec_ff;
      end else if (addr_in == `BCR_AMIN_OFF) begin
        nxt_rdata = amin_ff;
      end else if (addr_in == `BCR_AHOUR_OFF) begin
        nxt_rdata = ahour_ff;
      end else if (addr_in == `BCR_ADAY_OFF) begin
        nxt_rdata = aday_ff;
      end else if (addr_in == `BCR_AMON_OFF) begin
        nxt_rdata = amon_ff;
      end else if (addr_in == `BCR_AYEAR_OFF) begin
        nxt_rdata = ayear_ff;
      end else if (addr_in == `BCR_CTRL_OFF) begin
        nxt_rdata = ctrl_ff;
      end else if (addr_in == `BCR_STAT_OFF) begin
        nxt_rdata[`BCR_STAT_RUN_BIT] = ctrl_ff[`BCR_CTRL_RUN_BIT]; // [R8]
        nxt_rdata[`BCR_STAT_TICK_BIT] = tick_st_ff;
        nxt_rdata[`BCR_STAT_ALARM_BIT] = alarm_st_ff;
      end else if (addr_in == `BCR_IRQ_OFF) begin
        nxt_rdata = irqc_ff;
      end else if (addr_in == `BCR_COMPL_OFF) begin
        nxt_rdata = compl_ff;
      end else if (addr_in == `BCR_COMPM_OFF) begin
        nxt_rdata = compm_ff;
      end else if (addr_in >= `BCR_BCK_FIRST_OFF && addr_in <= `BCR_BCK_LAST_OFF) begin
        nxt_rdata = bck_ff[3'(addr_in - `BCR_BCK_FIRST_OFF)];
      end else if (addr_in == `BCR_SRC_OFF) begin
        nxt_rdata = {7'h00, xtal_ff};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Event outputs: sticky flags gated by enables; sleep hides the periodic one
  assign rdata_out = rdata_ff;
  assign periodic_event_irq_out = tick_st_ff && irqc_ff[`BCR_IRQ_TIMER_BIT] &&
      !(irqc_ff[`BCR_IRQ_SLEEPMASK_BIT] && sleep_sync_ff[1]); // [R10] [R12]
  assign alarm_event_irq_out = alarm_st_ff && irqc_ff[`BCR_IRQ_ALARM_BIT]; // [R11]
  assign wakeup_out = alarm_event_irq_out; // Periodic event never wakes [R13]
  assign crystal_select_out = xtal_ff;
endmodule

// [verif/bcr_rtc_sva.sv]
// Port-level assertions for the calendar clock core
`timescale 1ns/1ps
module bcr_rtc_sva (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sleep_in,
  input wire logic boot_select_0_in,
  input wire logic boot_select_1_in,
  input wire logic [7:0] addr_in,
  input wire bcr_pkg::bcr_byte_t wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire bcr_pkg::bcr_byte_t rdata_out,
  input wire logic periodic_event_irq_out,
  input wire logic alarm_event_irq_out,
  input wire logic wakeup_out,
  input wire logic crystal_select_out
);
  import bcr_pkg::*;
  bcr_byte_t ctl_ff, cfg_ff, nxt_ctl, nxt_cfg;
  // Shadow of control and event setup, so gating is judged from the bus alone
  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_cfg = cfg_ff;
    if (wr_in && addr_in == 8'h10) nxt_ctl = wdata_in;
    if (wr_in && addr_in == 8'h12) nxt_cfg = wdata_in;
  end
  // Shadow registers clear with the design, both start stopped and disabled
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_ff <= 8'h00;
      cfg_ff <= 8'h00;
    end else begin
      ctl_ff <= nxt_ctl;
      cfg_ff <= nxt_cfg;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_WAKE_ALARM: assert property (wakeup_out == alarm_event_irq_out)
    else $error("wakeup out of step with alarm event");
  AST_ALARM_GATE: assert property (!cfg_ff[3] |-> !alarm_event_irq_out)
    else $error("alarm event while its enable is clear");
  AST_PER_GATE: assert property (!cfg_ff[2] |-> !periodic_event_irq_out)
    else $error("periodic event while its enable is clear");
  // Sync delay of the sleep level is two flops, so three sampled highs are safe
  AST_SLEEP_MASK: assert property (cfg_ff[4] && $past(rst_n_in, 3) && sleep_in &&
      $past(sleep_in) && $past(sleep_in, 2) |-> !periodic_event_irq_out)
    else $error("periodic event seen while asleep and masked");
  AST_BOOT_SRC: assert property ($rose(rst_n_in) ##3 !boot_select_1_in |->
      crystal_select_out == boot_select_0_in)
    else $error("default clock source does not follow the straps");
  AST_RUN_FLAG: assert property (rd_in && addr_in == 8'h11 |=>
      rdata_out[1] == $past(ctl_ff[0]))
    else $error("running flag differs from run enable");
  AST_SEC_TOP: assert property (rd_in && addr_in[7:1] == 7'h00 |=> !rdata_out[7])
    else $error("top bit of seconds or minutes read as one");
  AST_WEEK_MAX: assert property (rd_in && addr_in == 8'h06 |=> rdata_out <= 8'h06)
    else $error("weekday above six");
  AST_HOUR_24: assert property (rd_in && addr_in == 8'h02 && !ctl_ff[3] |=>
      rdata_out <= 8'h23)
    else $error("hour out of range in 24-hour mode");
  AST_MON_RANGE: assert property (rd_in && addr_in == 8'h04 |=>
      rdata_out >= 8'h01 && rdata_out <= 8'h12)
    else $error("month out of range");
endmodule

// [verif/bcr_host.sv]
// Host processor model driving the register port of the calendar clock
`timescale 1ns/1ps
module bcr_host (
  input wire logic clk_in,
  input wire bcr_pkg::bcr_byte_t rdata_in,
  output logic [7:0] addr_out,
  output bcr_pkg::bcr_byte_t wdata_out,
  output logic wr_out,
  output logic rd_out
);
  import bcr_pkg::*;
  // Bus idles with both strobes low
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // One write cycle; bit 5 of control is always written as zero since the clock may run
  task automatic wr_reg(input logic [7:0] a, input bcr_byte_t d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= (a == 8'h10) ? (d & 8'hdf) : d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output bcr_byte_t d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
    d = rdata_in;
  endtask
  // Stop counting, then poll until the status shows the clock frozen
  task automatic freeze();
    bcr_byte_t s;
    wr_reg(8'h10, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd_reg(8'h11, s);
      if (s[1] === 1'b0) break;
    end
  endtask
  // Drift is loaded ahead of the hourly correction, low byte first
  task automatic load_drift(input logic [15:0] v);
    wr_reg(8'h13, v[7:0]);
    wr_reg(8'h14, v[15:8]);
  endtask
endmodule

// [verif/bcr_rtc_tb.sv]
// Self-checking bench for the calendar clock core
`timescale 1ns/1ps
module bcr_rtc_tb;
  import bcr_pkg::*;
  logic clk_in, rst_n_in, tick32_in, sleep_in, boot_select_0_in, boot_select_1_in;
  logic [7:0] addr_in;
  bcr_byte_t wdata_in, rdata_out;
  logic wr_in, rd_in, periodic_event_irq_out, alarm_event_irq_out, wakeup_out;
  logic crystal_select_out;
  int bad_count = 0;
  int check_count = 0;

  bcr_rtc dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .tick32_in(tick32_in),
    .sleep_in(sleep_in), .boot_select_0_in(boot_select_0_in),
    .boot_select_1_in(boot_select_1_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .periodic_event_irq_out(periodic_event_irq_out),
    .alarm_event_irq_out(alarm_event_irq_out), .wakeup_out(wakeup_out),
    .crystal_select_out(crystal_select_out));
  bcr_host host_u (.clk_in(clk_in), .rdata_in(rdata_out), .addr_out(addr_in),
    .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));

  // 20 MHz system clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic tally_and_finish();
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    bcr_byte_t v;
    host_u.rd_reg(a, v);
    chk(what, exp, v);
  endtask
  // Straps are held through reset; the source is judged once they have synced
  task automatic do_reset(input logic b0);
    @(posedge clk_in);
    boot_select_0_in <= b0;
    rst_n_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    chk("source after reset", {7'h00, b0}, {7'h00, crystal_select_out});
  endtask
  // Source edges one clock per phase; keeps a full second near 65k cycles
  task automatic pulses(input int n);
    repeat (n) begin
      tick32_in <= 1'b1;
      @(posedge clk_in);
      tick32_in <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  task automatic reset_and_store();
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
    int i;
    do_reset(1'b0);
    for (i = 0; i < 7; i++) begin
      rd_chk(i[7:0], rv[i], "time reset value");
    end
    rd_chk(8'h11, 8'h00, "status reset value");
    host_u.wr_reg(8'h00, 8'hb6);
    rd_chk(8'h00, 8'h36, "seconds top bit");
    for (i = 0; i < 5; i++) begin
      host_u.wr_reg(8'h17 + i[7:0], 8'ha0 + i[7:0]);
    end
    for (i = 0; i < 5; i++) begin
      rd_chk(8'h17 + i[7:0], 8'ha0 + i[7:0], "backup byte");
    end
    host_u.wr_reg(8'h07, 8'h5a);
    rd_chk(8'h07, 8'h00, "unmapped offset");
    host_u.wr_reg(8'h1f, 8'h01);
    repeat (2) @(posedge clk_in);
    chk("source switch", 8'h01, {7'h00, crystal_select_out});
  endtask
  // Leap-year February 28 at 23:59:59, weekday 6, alarm set for the next second
  task automatic leap_midnight();
    logic [7:0] ta [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
      8'h0b, 8'h0c, 8'h0d, 8'h12};
    logic [7:0] td [11] = '{8'h59, 8'h59, 8'h23, 8'h28, 8'h02, 8'h04, 8'h06,
      8'h29, 8'h02, 8'h04, 8'h1f};
    logic [7:0] ex [7] = '{8'h00, 8'h00, 8'h00, 8'h29, 8'h02, 8'h04, 8'h00};
    int i;
    sleep_in <= 1'b1;
    host_u.freeze();
    for (i = 0; i < 11; i++) begin
      host_u.wr_reg(ta[i], td[i]);
    end
    host_u.load_drift(16'h7ffe);
    host_u.wr_reg(8'h10, 8'h05);
    rd_chk(8'h11, 8'h02, "running flag");
    pulses(32767);
    rd_chk(8'h00, 8'h59, "seconds one edge early");
    pulses(1);
    for (i = 0; i < 60 && alarm_event_irq_out !== 1'b1; i++) begin
      @(posedge clk_in);
    end
    for (i = 0; i < 7; i++) begin
      rd_chk(i[7:0], ex[i], "midnight rollover");
    end
    rd_chk(8'h11, 8'h62, "event flags");
    chk("masked while asleep", 8'h00, {7'h00, periodic_event_irq_out});
    chk("alarm wakeup", 8'h01, {7'h00, wakeup_out});
    sleep_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk("periodic after wake", 8'h01, {7'h00, periodic_event_irq_out});
    host_u.wr_reg(8'h11, 8'h40);
    @(posedge clk_in);
    chk("periodic never wakes", 8'h00, {7'h00, wakeup_out});
    chk("periodic held", 8'h01, {7'h00, periodic_event_irq_out});
  endtask
  // Corrected second is two edges long; rounding 10:59:45 PM in twelve-hour mode
  task automatic round_twelve();
    int i;
    host_u.wr_reg(8'h11, 8'h20);
    host_u.wr_reg(8'h12, 8'h06);
    host_u.wr_reg(8'h10, 8'h0f);
    host_u.wr_reg(8'h02, 8'h90);
    host_u.wr_reg(8'h01, 8'h59);
    host_u.wr_reg(8'h00, 8'h45);
    pulses(1);
    rd_chk(8'h00, 8'h45, "seconds after one edge");
    pulses(1);
    for (i = 0; i < 60 && periodic_event_irq_out !== 1'b1; i++) begin
      @(posedge clk_in);
    end
    chk("hourly event", 8'h01, {7'h00, periodic_event_irq_out});
    rd_chk(8'h00, 8'h00, "rounded seconds");
    rd_chk(8'h01, 8'h00, "rounded minutes");
    rd_chk(8'h02, 8'h91, "rounded afternoon hour");
    rd_chk(8'h03, 8'h29, "day kept");
    rd_chk(8'h10, 8'h0d, "round bit cleared");
  endtask
  // Watchdog sized for one full second of source edges plus margin
  initial begin
    repeat (90000) @(posedge clk_in);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    rst_n_in = 1'b0;
    tick32_in = 1'b0;
    sleep_in = 1'b0;
    boot_select_0_in = 1'b0;
    boot_select_1_in = 1'b0;
    reset_and_store();
    do_reset(1'b1);
    leap_midnight();
    round_twelve();
    tally_and_finish();
  end
endmodule

bind bcr_rtc bcr_rtc_sva chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .sleep_in(sleep_in),
  .boot_select_0_in(boot_select_0_in), .boot_select_1_in(boot_select_1_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .periodic_event_irq_out(periodic_event_irq_out),
  .alarm_event_irq_out(alarm_event_irq_out), .wakeup_out(wakeup_out),
  .crystal_select_out(crystal_select_out));
